// ===== core/cdgc_pkg.sv
package cdgc_pkg;
  // Bus geometry
  localparam int unsigned CDGC_DATA_W  = 32;
  localparam int unsigned CDGC_REG_W   = 8;
  localparam int unsigned CDGC_DEC_W   = 8;
  // Byte offsets of the register words
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_EVT_STAT  = 8'h04;
  localparam logic [7:0] OFS_EVT_CLR   = 8'h08;
  localparam logic [7:0] OFS_EVT_EN    = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CFG   = 8'h10;
  localparam logic [7:0] OFS_PIN_STAT  = 8'h14;
  // Control register fields
  localparam int unsigned CTRL_RSVD_HI_LSB = 6;
  localparam int unsigned CTRL_SW_EVT_BIT  = 5;
  localparam int unsigned CTRL_RESUME_BIT  = 4;
  localparam int unsigned CTRL_RSVD_MD_LSB = 2;
  localparam int unsigned CTRL_CLR_EN_BIT  = 1;
  localparam int unsigned CTRL_RSVD_LO_BIT = 0;
  localparam logic [7:0]  CTRL_RESET       = 8'h00;
  localparam logic [7:0]  CTRL_STORE_MASK  = 8'hDF;
  // Event bits, same layout in status, clear and enable
  localparam int unsigned EVT_W          = 4;
  localparam int unsigned EVT_CHANGE_A   = 0;
  localparam int unsigned EVT_CHANGE_B   = 1;
  localparam int unsigned EVT_REMOVAL    = 2;
  localparam int unsigned EVT_RESUME     = 3;
  localparam logic [3:0]  EVT_EN_RESET   = 4'h0;
  // Interrupt configuration fields
  localparam int unsigned CFG_DET_EN_BIT = 3;
  localparam int unsigned CFG_SEL_LSB    = 4;
  localparam logic [7:0]  CFG_RESET      = 8'h00;
  localparam logic [7:0]  CFG_STORE_MASK = 8'hF8;
  localparam logic [7:0]  CFG_SEL_MASK   = 8'hF0;
  // Pin status fields
  localparam int unsigned PIN_CD1_BIT    = 0;
  localparam int unsigned PIN_CD2_BIT    = 1;
  localparam int unsigned PIN_RESUME_BIT = 2;
  localparam int unsigned PIN_PRESENT_BIT = 3;
  // Detect inputs idle high with no card
  localparam logic        CD_RESET_LEVEL = 1'b1;
  localparam logic [1:0]  SYNC_FILL      = 2'h2;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage

// ===== core/cdgc_cd_sync.sv
`timescale 1ns/1ps
`default_nettype none
module cdgc_cd_sync
  import cdgc_pkg::*;
#(
  parameter int unsigned W = 2
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] raw_n,
  output logic      [W-1:0] level_n,
  output logic      [W-1:0] change
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;
  logic [1:0]   fill_q;
  logic         primed;

  // Hide edges until the chain holds real samples
  assign primed  = (fill_q == SYNC_FILL);
  assign level_n = sync_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fill_q <= 2'h0;
    end else if (!primed) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // Two flops per pin, then one edge detector per pin
  for (genvar i = 0; i < W; i++) begin : g_pin
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta_q[i] <= CD_RESET_LEVEL;
        sync_q[i] <= CD_RESET_LEVEL;
        last_q[i] <= CD_RESET_LEVEL;
      end else begin
        meta_q[i] <= raw_n[i];
        sync_q[i] <= meta_q[i];
        last_q[i] <= sync_q[i];
      end
    end
    assign change[i] = primed & (sync_q[i] ^ last_q[i]);
  end
endmodule // cdgc_cd_sync
`default_nettype wire

// ===== core/cdgc_sticky.sv
`timescale 1ns/1ps
`default_nettype none
module cdgc_sticky
  import cdgc_pkg::*;
#(
  parameter int unsigned W = 4
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  input  wire logic [W-1:0] en,
  output logic      [W-1:0] status,
  output logic              irq
);
  logic [W-1:0] status_q;

  // Set beats clear so a same-cycle event survives
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        status_q[i] <= 1'b0;
      end else begin
        status_q[i] <= set[i] | (status_q[i] & ~clr[i]);
      end
    end
  end

  assign status = status_q;
  assign irq    = |(status_q & en);
endmodule // cdgc_sticky
`default_nettype wire

// ===== core/cdgc_ctrl.sv
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module cdgc_ctrl
  import cdgc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]        s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Socket pins
  input  wire logic              card_detect_1_n,
  input  wire logic              card_detect_2_n,
  output logic                   resume_indicate_out_n,
  // Socket side results
  output logic                   config_clear_pulse,
  output logic                   card_status_change_irq,
  output logic      [3:0]        status_change_irq_select,
  output logic                   irq
);
  // Decode needs the full offset space
  if (ADDR_W < CDGC_DEC_W) begin : g_chk
    $error("cdgc_ctrl: ADDR_W below 8 cannot reach the map");
  end

  // Bus holding state
  logic [ADDR_W-1:0] awaddr_q;
  logic              aw_held_q;
  logic [31:0]       wdata_q;
  logic [3:0]        wstrb_q;
  logic              w_held_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              rvalid_q;
  logic [1:0]        rresp_q;
  logic [31:0]       rdata_q;

  // Register state
  logic [7:0]        ctrl_q;
  logic [7:0]        ctrl_d;
  logic [7:0]        cfg_q;
  logic [7:0]        cfg_d;
  logic [EVT_W-1:0]  evt_en_q;
  logic              clear_pulse_q;

  // Event wiring
  logic [1:0]        cd_level_n;
  logic [1:0]        cd_change;
  logic [EVT_W-1:0]  evt_set;
  logic [EVT_W-1:0]  evt_clr;
  logic [EVT_W-1:0]  evt_status;
  logic              any_change;
  logic              both_high;
  logic              removal_fire;
  logic              sw_event;

  // Write decode wires
  logic              aw_hs;
  logic              w_hs;
  logic              wr_go;
  logic [7:0]        wr_ofs;
  logic              wr_hi_zero;
  logic              wr_lane0;
  logic [7:0]        wr_byte;
  logic              wr_ctrl;
  logic              wr_clr;
  logic              wr_en;
  logic              wr_cfg;
  logic              wr_mapped;
  logic              wr_at_ctrl;
  logic              wr_at_stat;
  logic              wr_at_clr;
  logic              wr_at_en;
  logic              wr_at_cfg;
  logic              wr_at_pin;

  // Read decode wires
  logic              ar_hs;
  logic [7:0]        rd_ofs;
  logic              rd_hi_zero;
  logic              rd_mapped;
  logic              rd_at_ctrl;
  logic              rd_at_stat;
  logic              rd_at_clr;
  logic              rd_at_en;
  logic              rd_at_cfg;
  logic              rd_at_pin;
  logic [7:0]        rd_byte;
  logic [7:0]        pin_stat;

  // Channel handshakes; one write in flight at a time
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready  = !w_held_q && !bvalid_q;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign wr_go         = aw_held_q && w_held_q && !bvalid_q;

  // Address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awaddr_q  <= '0;
    end else if (aw_hs) begin
      aw_held_q <= 1'b1;
      awaddr_q  <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else if (w_hs) begin
      w_held_q <= 1'b1;
      wdata_q  <= s_axi_wdata;
      wstrb_q  <= s_axi_wstrb;
    end else if (wr_go) begin
      w_held_q <= 1'b0;
    end
  end

  // Write decode; only byte lane 0 carries register bits
  assign wr_ofs     = {awaddr_q[7:2], 2'b00};
  assign wr_hi_zero = (awaddr_q >> CDGC_DEC_W) == '0;
  assign wr_lane0   = wstrb_q[0];
  assign wr_byte    = wdata_q[7:0];

  // One select per word; read-only words still answer OKAY
  assign wr_at_ctrl = wr_hi_zero && (wr_ofs == OFS_CTRL);
  assign wr_at_stat = wr_hi_zero && (wr_ofs == OFS_EVT_STAT);
  assign wr_at_clr  = wr_hi_zero && (wr_ofs == OFS_EVT_CLR);
  assign wr_at_en   = wr_hi_zero && (wr_ofs == OFS_EVT_EN);
  assign wr_at_cfg  = wr_hi_zero && (wr_ofs == OFS_IRQ_CFG);
  assign wr_at_pin  = wr_hi_zero && (wr_ofs == OFS_PIN_STAT);
  assign wr_mapped  = wr_at_ctrl || wr_at_stat || wr_at_clr ||
                      wr_at_en || wr_at_cfg || wr_at_pin;

  // Strobes fire once, in the cycle both halves are held
  assign wr_ctrl    = wr_go && wr_lane0 && wr_at_ctrl;
  assign wr_clr     = wr_go && wr_lane0 && wr_at_clr;
  assign wr_en      = wr_go && wr_lane0 && wr_at_en;
  assign wr_cfg     = wr_go && wr_lane0 && wr_at_cfg;

  // Response one cycle after both halves are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;

  // Control register: bit 5 is a strobe, never stored
  assign sw_event = wr_ctrl && wr_byte[CTRL_SW_EVT_BIT];
  assign ctrl_d   = wr_byte & CTRL_STORE_MASK;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= ctrl_d;
    end
  end

  // Interrupt config; select bits fall to zero on removal
  assign cfg_d = wr_cfg ? (wr_byte & CFG_STORE_MASK) : cfg_q;

  // Removal beats a same-cycle write so no stale select survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RESET;
    end else if (removal_fire) begin
      cfg_q <= cfg_d & ~CFG_SEL_MASK;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  // Event enable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_en_q <= EVT_EN_RESET;
    end else if (wr_en) begin
      evt_en_q <= wr_byte[EVT_W-1:0];
    end
  end

  // Detect pin synchroniser and edge detect
  cdgc_cd_sync #(
    .W (2)
  ) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .raw_n   ({card_detect_2_n, card_detect_1_n}),
    .level_n (cd_level_n),
    .change  (cd_change)
  );

  // Removal means both pins high after a change
  assign any_change   = |cd_change;
  assign both_high    = cd_level_n[0] && cd_level_n[1];
  assign removal_fire = any_change && both_high && ctrl_q[CTRL_CLR_EN_BIT];

  // Event sources; software strobe hits both flags
  assign evt_set[EVT_CHANGE_A] = cd_change[0] || sw_event;
  assign evt_set[EVT_CHANGE_B] = cd_change[1] || sw_event;
  assign evt_set[EVT_REMOVAL]  = removal_fire;
  assign evt_set[EVT_RESUME]   = any_change && ctrl_q[CTRL_RESUME_BIT];
  assign evt_clr               = wr_clr ? wr_byte[EVT_W-1:0] : '0;

  cdgc_sticky #(
    .W (EVT_W)
  ) u_evt (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (evt_set),
    .clr     (evt_clr),
    .en      (evt_en_q),
    .status  (evt_status),
    .irq     (irq)
  );

  // Resume pin held low until software clears its flag
  // Clearing bit 4 alone does not release it, so no wake is lost
  assign resume_indicate_out_n = !evt_status[EVT_RESUME];

  // One-cycle clear pulse toward the window registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clear_pulse_q <= 1'b0;
    end else begin
      clear_pulse_q <= removal_fire;
    end
  end

  // Outside registers listed for clearing all take this strobe
  assign config_clear_pulse = clear_pulse_q;

  // Status change interrupt from either detect flag
  assign card_status_change_irq = cfg_q[CFG_DET_EN_BIT] &&
                                  (evt_status[EVT_CHANGE_A] ||
                                   evt_status[EVT_CHANGE_B]);
  assign status_change_irq_select = cfg_q[CFG_SEL_LSB +: 4];

  // Live pin view for software; upper nibble reads zero
  assign pin_stat[7:4]             = 4'h0;
  assign pin_stat[PIN_CD1_BIT]     = cd_level_n[0];
  assign pin_stat[PIN_CD2_BIT]     = cd_level_n[1];
  assign pin_stat[PIN_RESUME_BIT]  = !evt_status[EVT_RESUME];
  assign pin_stat[PIN_PRESENT_BIT] = !both_high;

  // Read decode and data select
  assign s_axi_arready = !rvalid_q;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign rd_ofs        = {s_axi_araddr[7:2], 2'b00};
  assign rd_hi_zero    = (s_axi_araddr >> CDGC_DEC_W) == '0;

  // One select per word, shared by data and response
  assign rd_at_ctrl    = rd_hi_zero && (rd_ofs == OFS_CTRL);
  assign rd_at_stat    = rd_hi_zero && (rd_ofs == OFS_EVT_STAT);
  assign rd_at_clr     = rd_hi_zero && (rd_ofs == OFS_EVT_CLR);
  assign rd_at_en      = rd_hi_zero && (rd_ofs == OFS_EVT_EN);
  assign rd_at_cfg     = rd_hi_zero && (rd_ofs == OFS_IRQ_CFG);
  assign rd_at_pin     = rd_hi_zero && (rd_ofs == OFS_PIN_STAT);
  assign rd_mapped     = rd_at_ctrl || rd_at_stat || rd_at_clr ||
                         rd_at_en || rd_at_cfg || rd_at_pin;

  // Clear register is write-only, reads zero
  assign rd_byte = rd_at_ctrl ? ctrl_q :
                   rd_at_stat ? {4'h0, evt_status} :
                   rd_at_en   ? {4'h0, evt_en_q} :
                   rd_at_cfg  ? cfg_q :
                   rd_at_pin  ? pin_stat : 8'h00;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rresp_q  <= RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
    end else if (ar_hs) begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_q  <= {24'h00_0000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;
endmodule // cdgc_ctrl
`default_nettype wire

// ===== verification/cdgc_sock_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdgc_sock_model (
  input  wire logic aclk,
  input  wire logic seat,
  output var  logic card_detect_1_n,
  output var  logic card_detect_2_n
);
  // Empty socket: both contacts float up to the pull-up level
  initial begin
    card_detect_1_n = 1'b1;
    card_detect_2_n = 1'b1;
  end
  // Contacts make and break one cycle apart, as a real card slides
  always @(posedge aclk) begin
    card_detect_1_n <= !seat;
    card_detect_2_n <= card_detect_1_n;
  end
endmodule // cdgc_sock_model
`default_nettype wire

// ===== verification/cdgc_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cdgc_ctrl_chk (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       card_detect_1_n,
  input wire logic       card_detect_2_n,
  input wire logic       resume_indicate_out_n,
  input wire logic       config_clear_pulse,
  input wire logic [3:0] status_change_irq_select,
  input wire logic       irq
);
  // Cycles since the last pin edge; saturates so old edges never excuse a pin event
  logic [1:0] pins_q;
  logic [3:0] age_q;
  always_ff @(posedge aclk) begin
    pins_q <= {card_detect_2_n, card_detect_1_n};
    if (pins_q != {card_detect_2_n, card_detect_1_n}) age_q <= 4'h0;
    else if (!aresetn) age_q <= 4'hF;
    else if (age_q != 4'hF) age_q <= age_q + 4'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Bus timing and refusals
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer not on time");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not on time");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_rd_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  // Socket side effects
  a_resume_cause: assert property ($fell(resume_indicate_out_n) |-> age_q <= 4'h8)
    else $error("resume fell with no pin edge");
  a_resume_release: assert property ($rose(resume_indicate_out_n) |-> $rose(s_axi_bvalid))
    else $error("resume released without a write");
  a_pulse_once: assert property (config_clear_pulse |=> !config_clear_pulse)
    else $error("clear pulse longer than one cycle");
  a_pulse_cause: assert property (config_clear_pulse |->
    card_detect_1_n && card_detect_2_n && age_q <= 4'h8) else $error("clear pulse without removal");
  a_sel_cleared: assert property (config_clear_pulse |-> status_change_irq_select == 4'h0)
    else $error("select bits survived removal");
  c_pulse: cover property (config_clear_pulse);
  c_resume: cover property ($fell(resume_indicate_out_n));
  c_irq: cover property ($rose(irq));
endmodule // cdgc_ctrl_chk
bind cdgc_ctrl cdgc_ctrl_chk chk_u (.*);
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top import cdgc_pkg::*;;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [1:0] br;
    logic [7:0] rd;
    logic [1:0] rr;
    logic       irq;
    logic       csc;
  } cdgc_row_s;
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        seat          = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br;
  logic [31:0] s_axi_rdata, dv;
  logic        card_detect_1_n, card_detect_2_n, resume_indicate_out_n;
  logic        config_clear_pulse, card_status_change_irq, irq;
  logic [3:0]  status_change_irq_select;
  int          num_errors    = 0;
  int          checks        = 0;
  int          np;
  // Writes and reads with the irq levels each leaves behind
  cdgc_row_s rows [8] = '{
    '{8'h00, 8'hCD, RESP_OKAY, 8'hCD, RESP_OKAY, 1'b0, 1'b0},
    '{8'h00, 8'hFF, RESP_OKAY, 8'hDF, RESP_OKAY, 1'b0, 1'b0},
    '{8'h0C, 8'h0F, RESP_OKAY, 8'h0F, RESP_OKAY, 1'b1, 1'b0},
    '{8'h10, 8'hFF, RESP_OKAY, 8'hF8, RESP_OKAY, 1'b1, 1'b1},
    '{8'h20, 8'h55, RESP_SLVERR, 8'h00, RESP_SLVERR, 1'b1, 1'b1},
    '{8'h04, 8'h00, RESP_OKAY, 8'h03, RESP_OKAY, 1'b1, 1'b1},
    '{8'h08, 8'h03, RESP_OKAY, 8'h00, RESP_OKAY, 1'b0, 1'b0},
    '{8'h04, 8'h00, RESP_OKAY, 8'h00, RESP_OKAY, 1'b0, 1'b0}};
  cdgc_ctrl #(.ADDR_W(8)) dut_u (.*);
  cdgc_sock_model sock_u (
    .aclk            (aclk),
    .seat            (seat),
    .card_detect_1_n (card_detect_1_n),
    .card_detect_2_n (card_detect_2_n)
  );
  always #25 aclk = ~aclk;
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic c1(input string nm, input logic e, input logic g);
    chk(nm, {31'h0000_0000, e}, {31'h0000_0000, g});
  endtask
  // Readies are looked at mid-cycle, where they are settled, and used at the next edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa | pw) begin
      @(negedge aclk);
      ta = pa & s_axi_awready;
      tw = pw & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa & !ta;
      pw = pw & !tw;
    end
    do @(negedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [1:0] r;
    rd(a, dv, r);
    chk("rdata", {24'h00_0000, e}, dv);
    chk("rresp", {30'h0000_0000, RESP_OKAY}, {30'h0000_0000, r});
  endtask
  // Card moves, then clear pulses counted over a settled window
  task automatic move(input logic s);
    seat <= s;
    np = 0;
    repeat (12) begin
      @(negedge aclk);
      np += int'(config_clear_pulse);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Run is under two hundred cycles; this bound only catches a hang
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    $display("BAD watchdog expected done seen hang");
    end_of_test;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, br);
      chk("bresp", {30'h0000_0000, rows[i].br}, {30'h0000_0000, br});
      rd(rows[i].a, dv, br);
      chk("rdata", {24'h00_0000, rows[i].rd}, dv);
      chk("rresp", {30'h0000_0000, rows[i].rr}, {30'h0000_0000, br});
      c1("irq", rows[i].irq, irq);
      c1("csc", rows[i].csc, card_status_change_irq);
    end
    chk("select", 32'h0000_000F, {28'h000_0000, status_change_irq_select});
    move(1'b1);
    c1("resume_n", 1'b0, resume_indicate_out_n);
    c1("csc", 1'b1, card_status_change_irq);
    rc(8'h04, 8'h0B);
    rc(8'h14, 8'h08);
    wr(8'h08, 8'h0F, br);
    @(negedge aclk);
    c1("resume_n", 1'b1, resume_indicate_out_n);
    move(1'b0);
    chk("pulses", 32'h0000_0001, 32'(np));
    chk("select", 32'h0000_0000, {28'h000_0000, status_change_irq_select});
    rc(8'h10, 8'h08);
    rc(8'h00, 8'hDF);
    rc(8'h04, 8'h0F);
    // Reset in mid-run, then a card cycle with every control bit clear
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    c1("resume_n", 1'b1, resume_indicate_out_n);
    c1("irq", 1'b0, irq);
    rc(8'h00, 8'h00);
    rc(8'h0C, 8'h00);
    rc(8'h04, 8'h00);
    move(1'b1);
    move(1'b0);
    chk("pulses", 32'h0000_0000, 32'(np));
    c1("resume_n", 1'b1, resume_indicate_out_n);
    rc(8'h04, 8'h03);
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
